// >>> src/line_term_status.sv
// Lamp and state controller for a basic-rate network termination unit
//
// Implementation choices: the Wishbone interface to the registers and the address map.
module line_term_status
  import nt_status_pkg::*;
#(
  parameter logic [CNT_W-1:0] LAMP_CYC  = LAMP_TEST_CYC,
  parameter logic [CNT_W-1:0] ERR_CYC   = ERR_FLASH_CYC,
  parameter logic [CNT_W-1:0] QUIET_LEN = QUIET_CYC,
  parameter logic [CNT_W-1:0] BLINK_CYC = FLASH_HALF_CYC
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Status conditions
  input  wire logic             power_present_i,
  input  wire logic             power_good_i,
  input  wire logic             self_test_fail_i,
  input  wire logic             line_signal_i,
  input  wire logic             line_active_i,
  input  wire logic             line_frame_err_i,
  input  wire logic             sealing_current_i,
  input  wire logic             term_present_i,
  input  wire logic             term_info3_bad_i,
  input  wire logic             mechanized_loop_test_i,
  // Lamps and state
  output logic                  lamp_power_o,
  output logic                  lamp_line_err_o,
  output logic                  lamp_active_o,
  output logic                  lamp_term_err_o,
  output logic [2:0]            state_o,
  output logic                  irq_o,
  // Wishbone classic slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic [31:0]           wb_dat_o,
  output logic                  wb_ack_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    unit_state_t      st;
    logic [CNT_W-1:0] tmr;
    logic [CNT_W-1:0] qtmr;
    logic [3:0]       lamps;
    logic             ack;
    logic [31:0]      dat;
    logic             quiet_en;
    logic [EV_W-1:0]  irq_st;
    logic [EV_W-1:0]  irq_msk;
    logic             irq;
    logic             pgood;
  } regs_t;

  regs_t           r_ff;
  regs_t           nxt_r;
  logic            blink;
  logic [EV_W-1:0] ev;
  logic            take;
  logic            pw;

  flash_divider #(
    .HALF_CYC (BLINK_CYC)
  ) flash_divider_i (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .blink_o (blink)
  );

  // ----------------------------------------------------------------
  // Settled state from current line and terminal conditions
  // ----------------------------------------------------------------
  function automatic unit_state_t eval_state(
    input logic sig,
    input logic act,
    input logic ferr,
    input logic tpres,
    input logic i3bad
  );
    unit_state_t s;
    if (!sig && !tpres) begin
      s = ST_DEACT;
    end else if (!tpres || i3bad) begin
      // Terminal side decides over line activity and frame errors
      s = ST_TERM_ERR;
    end else if (!act || ferr) begin
      s = ST_PENDING;
    end else begin
      s = ST_ACTIVE;
    end
    return s;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_r       = r_ff;
    ev          = '0;
    take        = wb_cyc_i && wb_stb_i && !r_ff.ack;
    nxt_r.ack   = take;
    nxt_r.tmr   = r_ff.tmr + CNT_W'(1);
    nxt_r.qtmr  = r_ff.qtmr + CNT_W'(1);
    nxt_r.pgood = power_good_i;

    unique case (r_ff.st)
      ST_OFF: begin
        // Only a power return starts the
        if (power_present_i) begin
          nxt_r.st  = ST_SELF_TEST;
          nxt_r.tmr = '0;
        end
      end
      ST_SELF_TEST: begin
        if (r_ff.tmr == LAMP_CYC - CNT_W'(1)) begin
          nxt_r.tmr = '0;
          if (self_test_fail_i) begin
            nxt_r.st         = ST_INT_ERR;
            ev[EV_SELF_FAIL] = 1'b1;
          end else begin
            // Good test goes straight to the working state
            nxt_r.st = eval_state(line_signal_i, line_active_i, line_frame_err_i,
                                  term_present_i, term_info3_bad_i);
          end
        end
      end
      ST_INT_ERR: begin
        if (r_ff.tmr == ERR_CYC - CNT_W'(1)) begin
          nxt_r.st  = ST_SELF_TEST;
          nxt_r.tmr = '0;
        end
      end
      ST_QUIET: begin
        if (mechanized_loop_test_i) begin
          nxt_r.qtmr = '0;
        end else if (r_ff.qtmr == QUIET_LEN - CNT_W'(1)) begin
          ev[EV_QUIET_END] = 1'b1;
          nxt_r.st = eval_state(line_signal_i, line_active_i, line_frame_err_i,
                                term_present_i, term_info3_bad_i);
        end
      end
      ST_DEACT, ST_PENDING, ST_TERM_ERR, ST_ACTIVE: begin
        if (mechanized_loop_test_i && r_ff.quiet_en && line_signal_i) begin
          nxt_r.st   = ST_QUIET;
          nxt_r.qtmr = '0;
        end else begin
          // Frame errors park in pending only
          nxt_r.st = eval_state(line_signal_i, line_active_i, line_frame_err_i,
                                term_present_i, term_info3_bad_i);
        end
      end
    endcase

    // Loss of input power overrides everything
    if (!power_present_i) begin
      nxt_r.st = ST_OFF;
    end
    ev[EV_STATE_CHG] = nxt_r.st != r_ff.st;
    ev[EV_PWR_FAULT] = power_present_i && r_ff.pgood && !power_good_i;

    // Lamps follow the next state so they change with state_o
    pw = power_good_i ? 1'b1 : blink;
    unique case (nxt_r.st)
      ST_OFF:       nxt_r.lamps = 4'h0;
      ST_SELF_TEST: nxt_r.lamps = 4'hF;
      ST_INT_ERR:   nxt_r.lamps = {4{blink}};
      ST_DEACT:     nxt_r.lamps = {pw, 3'h0};
      ST_PENDING:   nxt_r.lamps = {pw, sealing_current_i ? 1'b1 : blink, 2'h0};
      ST_TERM_ERR:  nxt_r.lamps = {pw, 2'h0, 1'b1};
      ST_ACTIVE:    nxt_r.lamps = {pw, 1'b0, 1'b1, 1'b0};
      ST_QUIET:     nxt_r.lamps = {pw, 1'b0, blink, 1'b0};
    endcase

    // ----------------------------------------------------------------
    // Register access; one wait state, unmapped reads give zero
    // ----------------------------------------------------------------
    nxt_r.dat = '0;
    if (take && !wb_we_i) begin
      unique case (wb_adr_i)
        OFS_CTRL:    nxt_r.dat[CTRL_QUIET_EN] = r_ff.quiet_en;
        OFS_STATUS: begin
          nxt_r.dat[STAT_STATE_LSB +: 3] = r_ff.st;
          nxt_r.dat[STAT_LAMP_LSB +: 4]  = r_ff.lamps;
        end
        OFS_IRQ_ST:  nxt_r.dat[EV_W-1:0] = r_ff.irq_st;
        OFS_IRQ_MSK: nxt_r.dat[EV_W-1:0] = r_ff.irq_msk;
        default:     nxt_r.dat = '0;
      endcase
    end
    if (take && wb_we_i && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        OFS_CTRL:    nxt_r.quiet_en = wb_dat_i[CTRL_QUIET_EN];
        OFS_IRQ_MSK: nxt_r.irq_msk  = wb_dat_i[EV_W-1:0];
        default:     nxt_r.quiet_en = r_ff.quiet_en;
      endcase
    end
    // Read clears; a new event in the same cycle still sets
    if (take && !wb_we_i && wb_adr_i == OFS_IRQ_ST) begin
      nxt_r.irq_st = '0;
    end
    nxt_r.irq_st = nxt_r.irq_st | ev;
    nxt_r.irq    = |(nxt_r.irq_st & nxt_r.irq_msk);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Reset stands for power-up
      r_ff          <= '0;
      r_ff.st       <= ST_SELF_TEST;
      r_ff.lamps    <= 4'hF;
      r_ff.quiet_en <= CTRL_RESET;
      r_ff.irq_msk  <= IRQ_MSK_RESET;
      r_ff.pgood    <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign lamp_power_o    = r_ff.lamps[LAMP_POWER];
  assign lamp_line_err_o = r_ff.lamps[LAMP_LINE];
  assign lamp_active_o   = r_ff.lamps[LAMP_ACTIVE];
  assign lamp_term_err_o = r_ff.lamps[LAMP_TERM];
  assign state_o         = r_ff.st;
  assign irq_o           = r_ff.irq;
  assign wb_dat_o        = r_ff.dat;
  assign wb_ack_o        = r_ff.ack;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  test_lamps_on_a : assert property (
    r_ff.st == ST_SELF_TEST |-> r_ff.lamps == 4'hF)
    else $error("Lamp test not showing all lamps");

  test_length_a : assert property (
    $past(r_ff.st) == ST_SELF_TEST && r_ff.st != ST_SELF_TEST && r_ff.st != ST_OFF
    |-> $past(r_ff.tmr) == LAMP_CYC - CNT_W'(1))
    else $error("Self-test left at wrong time");

  test_entry_a : assert property (
    r_ff.st == ST_SELF_TEST && $past(r_ff.st) != ST_SELF_TEST
    |-> $past(r_ff.st) == ST_OFF || $past(r_ff.st) == ST_INT_ERR)
    else $error("Self-test entered from illegal state");

  err_retest_a : assert property (
    $past(r_ff.st) == ST_INT_ERR && r_ff.st == ST_SELF_TEST
    |-> $past(r_ff.tmr) == ERR_CYC - CNT_W'(1))
    else $error("Error flash ended at wrong time");

  err_flash_a : assert property (
    r_ff.st == ST_INT_ERR |-> r_ff.lamps == {4{$past(blink)}})
    else $error("Error state lamps not flashing together");

  deact_lamps_a : assert property (
    r_ff.st == ST_DEACT |-> r_ff.lamps[2:0] == 3'h0)
    else $error("Deactivated state lights extra lamps");

  pend_line_a : assert property (
    r_ff.st == ST_PENDING
    |-> r_ff.lamps[LAMP_LINE] == ($past(sealing_current_i) ? 1'b1 : $past(blink))
        && r_ff.lamps[1:0] == 2'h0)
    else $error("Pending state line lamp wrong");

  frame_err_a : assert property (
    $past(r_ff.st) == ST_ACTIVE && $past(line_frame_err_i) && $past(power_present_i)
    && $past(term_present_i) && !$past(term_info3_bad_i) && !$past(mechanized_loop_test_i)
    |-> r_ff.st == ST_PENDING)
    else $error("Frame error moved to wrong state");

  term_err_a : assert property (
    $past(r_ff.st) == ST_ACTIVE && $past(term_info3_bad_i) && $past(power_present_i)
    && ($past(line_signal_i) || $past(term_present_i)) && !$past(mechanized_loop_test_i)
    |-> r_ff.st == ST_TERM_ERR ##0 r_ff.lamps[LAMP_TERM])
    else $error("Bad terminal answer not reported");

  active_lamps_a : assert property (
    r_ff.st == ST_ACTIVE |-> r_ff.lamps[2:0] == 3'h2)
    else $error("Active state lamps wrong");

  quiet_lamps_a : assert property (
    r_ff.st == ST_QUIET
    |-> r_ff.lamps[LAMP_ACTIVE] == $past(blink) && r_ff.lamps[LAMP_LINE] == 1'b0)
    else $error("Quiet mode lamps wrong");

  quiet_timeout_a : assert property (
    r_ff.st == ST_QUIET |-> r_ff.qtmr < QUIET_LEN)
    else $error("Quiet mode outlived its timeout");

  quiet_retrig_a : assert property (
    $past(r_ff.st) == ST_QUIET && $past(mechanized_loop_test_i) && $past(power_present_i)
    |-> r_ff.st == ST_QUIET ##1 r_ff.qtmr == CNT_W'(1))
    else $error("Quiet retrigger did not restart timer");

  power_flash_a : assert property (
    r_ff.st >= ST_DEACT && !$past(power_good_i) |-> lamp_power_o == $past(blink))
    else $error("Bad power not flashing power lamp");

  power_steady_a : assert property (
    r_ff.st >= ST_DEACT && $past(power_good_i) |-> lamp_power_o)
    else $error("Good power lamp not steady");

  ack_pulse_a : assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("Bus acknowledge held longer than a cycle");

endmodule

// >>> src/nt_status_pkg.sv
// Shared constants and types for the termination status lamp controller
package nt_status_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W         = 34;
  localparam longint     CLK_KHZ       = 125000;
  localparam longint     LAMP_TEST_MS  = 1000;
  localparam longint     ERR_FLASH_MS  = 10000;
  localparam longint     QUIET_MS      = 75000;
  // Half period of the common blink; about 1.7 Hz
  localparam longint     FLASH_HALF_MS = 300;

  localparam logic [CNT_W-1:0] LAMP_TEST_CYC  = CNT_W'(LAMP_TEST_MS * CLK_KHZ);
  localparam logic [CNT_W-1:0] ERR_FLASH_CYC  = CNT_W'(ERR_FLASH_MS * CLK_KHZ);
  localparam logic [CNT_W-1:0] QUIET_CYC      = CNT_W'(QUIET_MS * CLK_KHZ);
  localparam logic [CNT_W-1:0] FLASH_HALF_CYC = CNT_W'(FLASH_HALF_MS * CLK_KHZ);

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADR_W       = 8;
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_STATUS  = 8'h04;
  localparam logic [7:0]  OFS_IRQ_ST  = 8'h08;
  localparam logic [7:0]  OFS_IRQ_MSK = 8'h0C;

  // Control fields
  localparam int unsigned CTRL_QUIET_EN = 0;
  localparam logic [0:0]  CTRL_RESET    = 1'h1;

  // Status fields
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_LAMP_LSB  = 4;

  // Interrupt event bits
  localparam int unsigned EV_W         = 4;
  localparam int unsigned EV_STATE_CHG = 0;
  localparam int unsigned EV_SELF_FAIL = 1;
  localparam int unsigned EV_QUIET_END = 2;
  localparam int unsigned EV_PWR_FAULT = 3;
  localparam logic [3:0]  IRQ_MSK_RESET = 4'h0;

  // Lamp vector bit positions
  localparam int unsigned LAMP_TERM   = 0;
  localparam int unsigned LAMP_ACTIVE = 1;
  localparam int unsigned LAMP_LINE   = 2;
  localparam int unsigned LAMP_POWER  = 3;

  // ----------------------------------------------------------------
  // Numbered unit states, codes 0 through 7 in order
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF,
    ST_SELF_TEST,
    ST_INT_ERR,
    ST_DEACT,
    ST_PENDING,
    ST_TERM_ERR,
    ST_ACTIVE,
    ST_QUIET
  } unit_state_t;

endpackage

// >>> src/flash_divider.sv
// Common blink phase generator for all flashing lamps
module flash_divider
  import nt_status_pkg::*;
#(
  parameter logic [CNT_W-1:0] HALF_CYC = FLASH_HALF_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      blink_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             phase;
  } div_t;

  div_t r_ff;
  div_t nxt_r;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // One shared divider keeps every flashing lamp in phase
  always_comb begin
    nxt_r     = r_ff;
    nxt_r.cnt = r_ff.cnt + CNT_W'(1);
    if (r_ff.cnt >= HALF_CYC - CNT_W'(1)) begin
      nxt_r.cnt   = '0;
      nxt_r.phase = !r_ff.phase;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign blink_o = r_ff.phase;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  blink_period_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    $changed(r_ff.phase) |-> $past(r_ff.cnt) == HALF_CYC - CNT_W'(1))
    else $error("Blink phase toggled at wrong count");

endmodule

// >>> tb/lamp_viewer.sv
// Installer model: classifies each lamp as off, on or flashing
module lamp_viewer #(
  parameter int WIN = 12
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       look_i,
  input  wire logic [3:0] lamp_i,
  output logic            done_o,
  output logic [7:0]      modes_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] hi_ff;
  logic [3:0] lo_ff;
  logic [3:0] hi_now;
  logic [3:0] lo_now;
  int         cnt_ff;
  logic       busy_ff;

  assign hi_now = hi_ff | lamp_i;
  assign lo_now = lo_ff | ~lamp_i;

  // Window longer than one blink period, so a flash shows both levels
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      busy_ff <= 1'b0;
      modes_o <= 8'h00;
    end else if (!busy_ff) begin
      busy_ff <= look_i;
      hi_ff <= 4'h0;
      lo_ff <= 4'h0;
      cnt_ff <= 0;
    end else begin
      hi_ff <= hi_now;
      lo_ff <= lo_now;
      cnt_ff <= cnt_ff + 1;
      if (cnt_ff == WIN - 1) begin
        busy_ff <= 1'b0;
        done_o <= 1'b1;
        for (int i = 0; i < 4; i++) begin
          modes_o[2*i +: 2] <= {hi_now[i] & lo_now[i], hi_now[i] & ~lo_now[i]};
        end
      end
    end
  end
endmodule

// >>> tb/line_term_status_test.sv
// Self-checking bench for the termination status lamp controller
module test_line_term_status
  import nt_status_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Shortened timers keep the run brief
  // ----------------------------------------------------------------
  localparam int LAMP = 20;
  localparam int ERRC = 50;
  localparam int QLEN = 40;
  localparam int BLK  = 4;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        pwr_on, pwr_ok, st_fail, sig, act, ferr, seal, term, bad3, loop_test;
  logic        cyc, stb, we, look, irq, ack, view_done;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat_w;
  logic [31:0] dat_r;
  logic [3:0]  lamps;
  logic [2:0]  state;
  logic [2:0]  es;
  logic [7:0]  view_modes;
  logic [31:0] seed = 32'h1E8FC3B9;
  logic [63:0] rq[$];
  logic [10:0] lq[$];
  int          err_count = 0;
  int          comparisons = 0;
  int          n;

  always #4 clk_i = ~clk_i;

  line_term_status #(
    .LAMP_CYC (CNT_W'(LAMP)),
    .ERR_CYC  (CNT_W'(ERRC)),
    .QUIET_LEN(CNT_W'(QLEN)),
    .BLINK_CYC(CNT_W'(BLK))
  ) line_term_status_i (
    .clk_i(clk_i), .rst_i(rst_i), .power_present_i(pwr_on), .power_good_i(pwr_ok),
    .self_test_fail_i(st_fail), .line_signal_i(sig), .line_active_i(act),
    .line_frame_err_i(ferr), .sealing_current_i(seal), .term_present_i(term),
    .term_info3_bad_i(bad3), .mechanized_loop_test_i(loop_test),
    .lamp_power_o(lamps[3]), .lamp_line_err_o(lamps[2]), .lamp_active_o(lamps[1]),
    .lamp_term_err_o(lamps[0]), .state_o(state), .irq_o(irq),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack)
  );

  lamp_viewer lamp_viewer_i (
    .clk_i(clk_i), .rst_i(rst_i), .look_i(look), .lamp_i(lamps),
    .done_o(view_done), .modes_o(view_modes)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cmp_val(input string name, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic cmp_reg(input logic [63:0] nt);
    cmp_val("wb_dat_o", nt[31:0] & nt[63:32], dat_r & nt[63:32]);
  endtask

  task automatic cmp_view(input logic [10:0] nt);
    cmp_val("state_o", 32'(nt[10:8]), 32'(state));
    cmp_val("lamp modes", 32'(nt[7:0]), 32'(view_modes));
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] exp_modes(input logic [2:0] s, input logic sl, input logic ok);
    logic [1:0] p;
    p = ok ? 2'h1 : 2'h2;
    case (s)
      3'h3: return {p, 6'h00};
      3'h4: return {p, sl ? 2'h1 : 2'h2, 4'h0};
      3'h5: return {p, 6'h01};
      default: return {p, 6'h04};
    endcase
  endfunction

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  // Reads note the expected word; writes expect an idle data bus
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] care, input logic [3:0] s);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= s;
    rq.push_back(w ? {32'hFFFFFFFF, 32'h0} : {care, d});
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) begin
      err_count++;
      stop_test();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic view(input logic [2:0] s, input logic [7:0] m);
    int k;
    @(posedge clk_i);
    look <= 1'b1;
    lq.push_back({s, m});
    @(posedge clk_i);
    look <= 1'b0;
    k = 0;
    while (view_done !== 1'b1 && k < 30) begin
      @(posedge clk_i);
      k++;
    end
    if (view_done !== 1'b1) begin
      err_count++;
      stop_test();
    end
  endtask

  task automatic wait_state(input logic [2:0] s, input int lim);
    int k;
    k = 0;
    while (state !== s && k < lim) begin
      @(posedge clk_i);
      k++;
    end
    if (state !== s) begin
      err_count++;
      $display("[ERR] state_o expected %h seen %h", s, state);
      stop_test();
    end
  endtask

  task automatic dwell(input logic [2:0] s, output int k);
    k = 0;
    while (state === s && k < 500) begin
      @(posedge clk_i);
      k++;
    end
  endtask

  task automatic pulse_lt();
    @(posedge clk_i);
    loop_test <= 1'b1;
    @(posedge clk_i);
    loop_test <= 1'b0;
  endtask

  always @(posedge clk_i) begin
    if (ack === 1'b1 && rq.size() > 0) cmp_reg(rq.pop_front());
    if (view_done === 1'b1 && lq.size() > 0) cmp_view(lq.pop_front());
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {pwr_on, pwr_ok, sig, act, seal, term} = 6'h3F;
    {st_fail, ferr, bad3, loop_test, cyc, stb, we, look} = 8'h00;
    adr = 8'h00;
    sel = 4'h0;
    dat_w = 32'h0;
    tick(3);
    rst_i <= 1'b0;
    view(3'h1, 8'h55);
    wait_state(3'h6, LAMP + 4);
    view(3'h6, 8'h44);
    wb(1'b0, OFS_CTRL, 32'h1, 32'hFFFFFFFF, 4'hF);
    wb(1'b0, OFS_IRQ_MSK, 32'h0, 32'hFFFFFFFF, 4'hF);
    wb(1'b0, 8'h10, 32'h0, 32'hFFFFFFFF, 4'hF);
    wb(1'b0, OFS_STATUS, 32'hA6, 32'hFFFFFFFF, 4'hF);
    wb(1'b0, OFS_IRQ_ST, 32'h1, 32'hFFFFFFFF, 4'hF);
    wb(1'b0, OFS_IRQ_ST, 32'h0, 32'hFFFFFFFF, 4'hF);
    wb(1'b1, OFS_CTRL, 32'h0, 32'h0, 4'hE);
    wb(1'b0, OFS_CTRL, 32'h1, 32'hFFFFFFFF, 4'hF);
    wb(1'b1, OFS_IRQ_MSK, 32'h1, 32'h0, 4'hF);
    term <= 1'b0;
    wait_state(3'h5, 4);
    tick(2);
    cmp_val("irq_o", 32'h1, 32'(irq));
    wb(1'b1, OFS_IRQ_MSK, 32'h0, 32'h0, 4'hF);
    tick(2);
    cmp_val("irq_o", 32'h0, 32'(irq));
    wb(1'b1, OFS_IRQ_MSK, 32'h1, 32'h0, 4'hF);
    tick(2);
    cmp_val("irq_o", 32'h1, 32'(irq));
    wb(1'b0, OFS_IRQ_ST, 32'h1, 32'h1, 4'hF);
    tick(2);
    cmp_val("irq_o", 32'h0, 32'(irq));
    // Random line, terminal and power conditions
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      @(posedge clk_i);
      {sig, act, ferr, term, seal} <= seed[4:0];
      bad3 <= seed[5] & seed[6];
      pwr_ok <= seed[7] | seed[8];
      tick(3);
      if (!sig && !term) es = 3'h3;
      else if (!term || bad3) es = 3'h5;
      else if (!act || ferr) es = 3'h4;
      else es = 3'h6;
      view(es, exp_modes(es, seal, pwr_ok));
    end
    {sig, act, term, seal, pwr_ok} <= 5'h1F;
    ferr <= 1'b0;
    bad3 <= 1'b0;
    wait_state(3'h6, 4);
    st_fail <= 1'b1;
    tick(30);
    cmp_val("state_o", 32'h6, 32'(state));
    pwr_on <= 1'b0;
    wait_state(3'h0, 4);
    view(3'h0, 8'h00);
    pwr_on <= 1'b1;
    wait_state(3'h1, 4);
    dwell(3'h1, n);
    cmp_val("self test length", 32'h1, 32'(n >= LAMP - 2 && n <= LAMP + 2));
    view(3'h2, 8'hAA);
    st_fail <= 1'b0;
    wait_state(3'h1, ERRC + 4);
    wait_state(3'h6, LAMP + 4);
    wb(1'b0, OFS_IRQ_ST, 32'h2, 32'h2, 4'hF);
    pulse_lt();
    wait_state(3'h7, 4);
    view(3'h7, 8'h48);
    tick(10);
    pulse_lt();
    dwell(3'h7, n);
    cmp_val("quiet length", 32'h1, 32'(n >= QLEN - 3 && n <= QLEN + 2));
    wait_state(3'h6, 4);
    wb(1'b0, OFS_IRQ_ST, 32'h4, 32'h4, 4'hF);
    wb(1'b1, OFS_CTRL, 32'h0, 32'h0, 4'hF);
    pulse_lt();
    tick(4);
    cmp_val("state_o", 32'h6, 32'(state));
    tick(2);
    stop_test();
  end
endmodule
